// file: common/clkgen_regs_pkg.sv
// Constants shared by the serial engine and the register bank
`default_nettype none
package clkgen_regs_pkg;
   // ----------------------------------------------------------------
   // Register indices
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_DIFF_EDGE = 8'h02;
   localparam logic [7:0] IDX_REF_CTRL  = 8'h03;
   localparam logic [7:0] IDX_RSVD_ONES = 8'h04;
   localparam logic [7:0] IDX_REV_MAKER = 8'h05;
   localparam logic [7:0] IDX_FAMILY    = 8'h06;
   localparam logic [7:0] IDX_RD_LENGTH = 8'h07;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int         REF_RATE_LSB    = 6;
   localparam int         REF_WOL_BIT     = 5;
   localparam int         REF_EN_BIT      = 4;
   localparam logic [3:0] DIFF_EDGE_RST   = 4'hF;
   localparam logic [1:0] REF_RATE_RST    = 2'h1;
   localparam logic       REF_WOL_RST     = 1'b0;
   localparam logic       REF_EN_RST      = 1'b1;
   localparam logic [3:0] REF_RSVD_BITS   = 4'hF;
   localparam logic [7:0] RSVD_BYTE_VALUE = 8'hFF;
   localparam logic [4:0] RD_LENGTH_RST   = 5'h08;
   localparam logic [7:0] UNMAPPED_VALUE  = 8'h00;

   // ----------------------------------------------------------------
   // Identification codes (values are arbitrary)
   // ----------------------------------------------------------------
   localparam logic [3:0] REV_CODE    = 4'h2;
   localparam logic [3:0] MAKER_CODE  = 4'hA;
   localparam logic [1:0] FAMILY_CODE = 2'h2;
   localparam logic [5:0] PART_CODE   = 6'h2B;

   // ----------------------------------------------------------------
   // Serial engine
   // ----------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5C;  // arbitrary
   localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
   localparam logic [3:0] LAST_TX_BIT      = 4'h7;

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TX_ACK, ST_TX_NEXT} eng_state_t;
   typedef enum logic [1:0] {ROLE_ADDR, ROLE_INDEX, ROLE_COUNT, ROLE_DATA} rx_role_t;
endpackage
`default_nettype wire

// file: common/regbus_if.sv
// Byte-wide register access between serial engine and register bank
`default_nettype none
interface regbus_if;
   logic       we;
   logic [7:0] waddr;
   logic [7:0] wdata;
   logic [7:0] raddr;
   logic [7:0] rdata;
   logic [4:0] byte_count;

   modport engine (output we, output waddr, output wdata, output raddr,
                   input rdata, input byte_count);
   modport bank   (input we, input waddr, input wdata, input raddr,
                   output rdata, output byte_count);
endinterface
`default_nettype wire

// file: rtl/clkgen_reg_bank.sv
// Control and identification register bank
`default_nettype none
module clkgen_reg_bank (
   input  wire logic ref_clk,
   input  wire logic rstn,
   regbus_if.bank    rb,
   output logic [3:0] edge_rate_sel_out,
   output logic [1:0] ref_edge_rate,
   output logic       ref_run_in_pd,
   output logic       ref_out_en
);
   logic [3:0] diff_q, diff_d;
   logic [1:0] rate_q, rate_d;
   logic       wol_q, wol_d;
   logic       en_q, en_d;
   logic [4:0] len_q, len_d;

   // ----------------------------------------------------------------
   // Writes; read-only and reserved bits simply drop the data
   // ----------------------------------------------------------------
   always_comb begin
      diff_d = diff_q;
      rate_d = rate_q;
      wol_d  = wol_q;
      en_d   = en_q;
      len_d  = len_q;
      if (rb.we) begin
         unique case (rb.waddr)
            clkgen_regs_pkg::IDX_DIFF_EDGE: diff_d = rb.wdata[3:0];
            clkgen_regs_pkg::IDX_REF_CTRL: begin
               rate_d = rb.wdata[clkgen_regs_pkg::REF_RATE_LSB +: 2];
               wol_d  = rb.wdata[clkgen_regs_pkg::REF_WOL_BIT];
               en_d   = rb.wdata[clkgen_regs_pkg::REF_EN_BIT];
            end
            clkgen_regs_pkg::IDX_RD_LENGTH: len_d = rb.wdata[4:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         diff_q <= clkgen_regs_pkg::DIFF_EDGE_RST;
         rate_q <= clkgen_regs_pkg::REF_RATE_RST;
         wol_q  <= clkgen_regs_pkg::REF_WOL_RST;
         en_q   <= clkgen_regs_pkg::REF_EN_RST;
         len_q  <= clkgen_regs_pkg::RD_LENGTH_RST;
      end else begin
         diff_q <= diff_d;
         rate_q <= rate_d;
         wol_q  <= wol_d;
         en_q   <= en_d;
         len_q  <= len_d;
      end
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb begin
      unique case (rb.raddr)
         clkgen_regs_pkg::IDX_DIFF_EDGE: rb.rdata = {4'h0, diff_q};
         clkgen_regs_pkg::IDX_REF_CTRL:
            rb.rdata = {rate_q, wol_q, en_q, clkgen_regs_pkg::REF_RSVD_BITS};
         clkgen_regs_pkg::IDX_RSVD_ONES: rb.rdata = clkgen_regs_pkg::RSVD_BYTE_VALUE;
         clkgen_regs_pkg::IDX_REV_MAKER:
            rb.rdata = {clkgen_regs_pkg::REV_CODE, clkgen_regs_pkg::MAKER_CODE};
         clkgen_regs_pkg::IDX_FAMILY:
            rb.rdata = {clkgen_regs_pkg::FAMILY_CODE, clkgen_regs_pkg::PART_CODE};
         clkgen_regs_pkg::IDX_RD_LENGTH: rb.rdata = {3'h0, len_q};
         default: rb.rdata = clkgen_regs_pkg::UNMAPPED_VALUE;
      endcase
   end

   assign rb.byte_count     = len_q;
   assign edge_rate_sel_out = diff_q;
   assign ref_edge_rate     = rate_q;
   assign ref_run_in_pd     = wol_q;
   assign ref_out_en        = en_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   diff_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      rb.we && rb.waddr == clkgen_regs_pkg::IDX_DIFF_EDGE
      |=> edge_rate_sel_out == $past(rb.wdata[3:0]))
      else $error("diff edge rate not updated");
   ref_rate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      rb.we && rb.waddr == clkgen_regs_pkg::IDX_REF_CTRL
      |=> ref_edge_rate == $past(rb.wdata[7:6]))
      else $error("ref edge rate not updated");
   wol_bit_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      rb.we && rb.waddr == clkgen_regs_pkg::IDX_REF_CTRL
      |=> ref_run_in_pd == $past(rb.wdata[5]))
      else $error("power-down run bit wrong");
   ref_enable_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      !(rb.we && rb.waddr == clkgen_regs_pkg::IDX_REF_CTRL) |=> $stable(ref_out_en))
      else $error("ref enable changed without write");
   rsvd_ones_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      rb.raddr == 8'h04 |-> rb.rdata == 8'hFF)
      else $error("reserved byte not all ones");
   rev_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      rb.raddr == 8'h05 |-> rb.rdata == {clkgen_regs_pkg::REV_CODE, clkgen_regs_pkg::MAKER_CODE})
      else $error("revision byte wrong");
   part_code_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      rb.raddr == 8'h06 |-> rb.rdata == {clkgen_regs_pkg::FAMILY_CODE, clkgen_regs_pkg::PART_CODE})
      else $error("part byte wrong");
   count_field_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      rb.we && rb.waddr == 8'h07 |=> rb.byte_count == $past(rb.wdata[4:0]))
      else $error("byte count not updated");
   ro_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      rb.we && rb.waddr inside {8'h04, 8'h05, 8'h06}
      |=> $stable({diff_q, rate_q, wol_q, en_q, len_q}))
      else $error("read-only write changed state");
endmodule
`default_nettype wire

// file: rtl/clock_gen_control_regs.sv
// Serial-bus block transfer engine and top of the control registers
`default_nettype none
// Operation
// - Index 2 bits 3:0 pick differential edge rates
// - Index 3 bits 7:6 pick reference edge rate
// - Index 3 bit 5 keeps reference running
// - Index 3 bit 4 enables reference output
// - Index 4 always reads all ones
// - Index 5 returns fixed revision, maker codes
// - Index 6 returns fixed family, part codes
// - Index 7 bits 4:0 set the byte count a block read reports first
// - Block write: index, count, data, all acknowledged
// - Block read returns count then data bytes
module clock_gen_control_regs #(
   parameter logic [6:0] DEV_ADDR = clkgen_regs_pkg::DEV_ADDR_DEFAULT
) (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   output logic [3:0]      edge_rate_sel_out,
   output logic [1:0]      ref_edge_rate,
   output logic            ref_run_in_pd,
   output logic            ref_out_en
);
   regbus_if rb ();

   clkgen_reg_bank u_bank (
      .ref_clk           (ref_clk),
      .rstn              (rstn),
      .rb                (rb),
      .edge_rate_sel_out (edge_rate_sel_out),
      .ref_edge_rate     (ref_edge_rate),
      .ref_run_in_pd     (ref_run_in_pd),
      .ref_out_en        (ref_out_en)
   );

   // ----------------------------------------------------------------
   // Bus line history and condition detect
   // ----------------------------------------------------------------
   logic scl_q, sda_q;
   logic scl_rise, scl_fall, start_cond, stop_cond;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda_in;
      end
   end

   assign scl_rise   = scl && !scl_q;
   assign scl_fall   = !scl && scl_q;
   // Data may only change while the clock is low; a change with clock high frames
   assign start_cond = scl && scl_q && sda_q && !sda_in;
   assign stop_cond  = scl && scl_q && !sda_q && sda_in;

   // ----------------------------------------------------------------
   // Transfer state
   // ----------------------------------------------------------------
   clkgen_regs_pkg::eng_state_t st_q, st_d;
   clkgen_regs_pkg::rx_role_t   role_q, role_d;
   logic [3:0]                  cnt_q, cnt_d;
   logic [7:0]                  sh_q, sh_d;
   logic [7:0]                  idx_q, idx_d;
   logic [7:0]                  rem_q, rem_d;
   logic                        rd_q, rd_d;
   logic                        first_q, first_d;
   logic                        oe_q, oe_d;

   always_comb begin
      st_d       = st_q;
      role_d     = role_q;
      cnt_d      = cnt_q;
      sh_d       = sh_q;
      idx_d      = idx_q;
      rem_d      = rem_q;
      rd_d       = rd_q;
      first_d    = first_q;
      rb.we      = 1'b0;
      rb.waddr   = idx_q;
      rb.wdata   = sh_q;
      rb.raddr   = idx_q;
      if (stop_cond) begin
         st_d = clkgen_regs_pkg::ST_IDLE;
      end else if (start_cond) begin
         // Repeated start keeps the index set by the preceding write phase
         st_d   = clkgen_regs_pkg::ST_RX;
         role_d = clkgen_regs_pkg::ROLE_ADDR;
         cnt_d  = 4'h0;
      end else begin
         unique case (st_q)
            clkgen_regs_pkg::ST_IDLE: ;
            clkgen_regs_pkg::ST_RX: begin
               if (cnt_q != clkgen_regs_pkg::BITS_PER_BYTE) begin
                  if (scl_rise) begin
                     sh_d  = {sh_q[6:0], sda_in};
                     cnt_d = cnt_q + 4'h1;
                  end
               end else if (scl_fall) begin
                  st_d = clkgen_regs_pkg::ST_ACK;
                  unique case (role_q)
                     clkgen_regs_pkg::ROLE_ADDR: begin
                        if (sh_q[7:1] == DEV_ADDR) begin
                           rd_d    = sh_q[0];
                           first_d = 1'b1;
                           role_d  = clkgen_regs_pkg::ROLE_INDEX;
                        end else begin
                           st_d = clkgen_regs_pkg::ST_IDLE;
                        end
                     end
                     clkgen_regs_pkg::ROLE_INDEX: begin
                        idx_d  = sh_q;
                        role_d = clkgen_regs_pkg::ROLE_COUNT;
                     end
                     clkgen_regs_pkg::ROLE_COUNT: begin
                        rem_d  = sh_q;
                        role_d = clkgen_regs_pkg::ROLE_DATA;
                     end
                     clkgen_regs_pkg::ROLE_DATA: begin
                        // Bytes past the announced count are acknowledged and dropped
                        if (rem_q != 8'h00) begin
                           rb.we = 1'b1;
                           idx_d = idx_q + 8'h01;
                           rem_d = rem_q - 8'h01;
                        end
                     end
                  endcase
               end
            end
            clkgen_regs_pkg::ST_ACK: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (rd_q) begin
                     st_d    = clkgen_regs_pkg::ST_TX;
                     first_d = 1'b0;
                     if (first_q) begin
                        sh_d = {3'h0, rb.byte_count};
                     end else begin
                        sh_d  = rb.rdata;
                        idx_d = idx_q + 8'h01;
                     end
                  end else begin
                     st_d = clkgen_regs_pkg::ST_RX;
                  end
               end
            end
            clkgen_regs_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (cnt_q == clkgen_regs_pkg::LAST_TX_BIT) begin
                     st_d = clkgen_regs_pkg::ST_TX_ACK;
                  end else begin
                     sh_d  = {sh_q[6:0], 1'b1};
                     cnt_d = cnt_q + 4'h1;
                  end
               end
            end
            clkgen_regs_pkg::ST_TX_ACK: begin
               // Host answers the last byte with a not-acknowledge
               if (scl_rise) begin
                  st_d = sda_in ? clkgen_regs_pkg::ST_IDLE : clkgen_regs_pkg::ST_TX_NEXT;
               end
            end
            clkgen_regs_pkg::ST_TX_NEXT: begin
               if (scl_fall) begin
                  st_d  = clkgen_regs_pkg::ST_TX;
                  cnt_d = 4'h0;
                  sh_d  = rb.rdata;
                  idx_d = idx_q + 8'h01;
               end
            end
            default: st_d = clkgen_regs_pkg::ST_IDLE;
         endcase
      end
      // Open drain: only ever pull low, for acknowledge or a zero data bit
      oe_d = (st_d == clkgen_regs_pkg::ST_ACK) ||
             (st_d == clkgen_regs_pkg::ST_TX && !sh_d[7]);
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q    <= clkgen_regs_pkg::ST_IDLE;
         role_q  <= clkgen_regs_pkg::ROLE_ADDR;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         idx_q   <= 8'h00;
         rem_q   <= 8'h00;
         rd_q    <= 1'b0;
         first_q <= 1'b0;
         oe_q    <= 1'b0;
      end else begin
         st_q    <= st_d;
         role_q  <= role_d;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         idx_q   <= idx_d;
         rem_q   <= rem_d;
         rd_q    <= rd_d;
         first_q <= first_d;
         oe_q    <= oe_d;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe  = oe_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   wr_store_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_RX && role_q == clkgen_regs_pkg::ROLE_DATA &&
      cnt_q == 4'h8 && scl_fall && rem_q != 8'h00 && !start_cond && !stop_cond
      |-> rb.we ##1 (st_q == clkgen_regs_pkg::ST_ACK && sda_oe && idx_q == $past(idx_q) + 8'h01))
      else $error("write byte not stored and acknowledged");

   ack_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_ACK |-> sda_oe)
      else $error("acknowledge not driven");

   read_count_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_ACK && rd_q && first_q && scl_fall && !start_cond && !stop_cond
      |=> st_q == clkgen_regs_pkg::ST_TX && sh_q == {3'h0, rb.byte_count})
      else $error("block read did not start with byte count");

   nack_end_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_TX_ACK && scl_rise && sda_in && !stop_cond
      |=> st_q == clkgen_regs_pkg::ST_IDLE ##1 !sda_oe)
      else $error("not-acknowledge did not end the read");

   // ----------------------------------------------------------------
   // Sequencing checks
   // ----------------------------------------------------------------
   own_addr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_RX && role_q == clkgen_regs_pkg::ROLE_ADDR &&
      cnt_q == 4'h8 && scl_fall && sh_q[7:1] == DEV_ADDR
      |=> st_q == clkgen_regs_pkg::ST_ACK && sda_oe &&
          role_q == clkgen_regs_pkg::ROLE_INDEX)
      else $error("own address not acknowledged");

   foreign_addr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_RX && role_q == clkgen_regs_pkg::ROLE_ADDR &&
      cnt_q == 4'h8 && scl_fall && sh_q[7:1] != DEV_ADDR
      |=> st_q == clkgen_regs_pkg::ST_IDLE && !sda_oe)
      else $error("foreign address acknowledged");

   index_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_RX && role_q == clkgen_regs_pkg::ROLE_INDEX &&
      cnt_q == 4'h8 && scl_fall
      |=> idx_q == $past(sh_q) && role_q == clkgen_regs_pkg::ROLE_COUNT)
      else $error("start index not taken");

   count_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_RX && role_q == clkgen_regs_pkg::ROLE_COUNT &&
      cnt_q == 4'h8 && scl_fall
      |=> rem_q == $past(sh_q) && role_q == clkgen_regs_pkg::ROLE_DATA)
      else $error("byte count not taken");

   extra_drop_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_RX && role_q == clkgen_regs_pkg::ROLE_DATA &&
      cnt_q == 4'h8 && scl_fall && rem_q == 8'h00
      |-> !rb.we ##1 (sda_oe && idx_q == $past(idx_q)))
      else $error("byte past count was stored");

   bit_sample_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_RX && cnt_q != 4'h8 && scl_rise
      |=> cnt_q == $past(cnt_q) + 4'h1 &&
          sh_q[0] == $past(sda_in))
      else $error("data bit not sampled on clock rise");

   tx_shift_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_TX && scl_fall && cnt_q != 4'h7
      |=> st_q == clkgen_regs_pkg::ST_TX && cnt_q == $past(cnt_q) + 4'h1 &&
          sda_oe == !sh_q[7])
      else $error("read bit not advanced");

   tx_last_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_TX && scl_fall && cnt_q == 4'h7
      |=> st_q == clkgen_regs_pkg::ST_TX_ACK && !sda_oe)
      else $error("line not released for host answer");

   host_ack_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_TX_ACK && scl_rise && !sda_in
      |=> st_q == clkgen_regs_pkg::ST_TX_NEXT && !sda_oe)
      else $error("host acknowledge not followed");

   next_byte_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_q == clkgen_regs_pkg::ST_TX_NEXT && scl_fall
      |=> st_q == clkgen_regs_pkg::ST_TX && sh_q == $past(rb.rdata) &&
          idx_q == $past(idx_q) + 8'h01)
      else $error("next read byte not loaded");

   restart_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      start_cond
      |=> st_q == clkgen_regs_pkg::ST_RX && role_q == clkgen_regs_pkg::ROLE_ADDR &&
          cnt_q == 4'h0 && idx_q == $past(idx_q))
      else $error("start did not restart with index kept");

   stop_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      stop_cond |=> st_q == clkgen_regs_pkg::ST_IDLE && !sda_oe)
      else $error("stop did not end the transfer");
endmodule
`default_nettype wire

// file: verification/smbus_host_model.sv
// Serial-bus host model issuing indexed block writes and reads
`default_nettype none
module smbus_host_model (
   input  wire logic ref_clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // Line primitives
   // ----------------------------------------------------------------
   // At least four cycles per level keeps every level well above the two-cycle minimum
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic half();
      repeat (4) @(negedge ref_clk);
   endtask

   // Data moves one cycle after scl falls, never with it, so no false start
   task automatic bit_out(input logic b, output logic seen);
      @(negedge ref_clk);
      sda_low = !b;
      half();
      scl = 1'b1;
      half();
      seen = sda;
      scl = 1'b0;
   endtask

   task automatic start_cond();
      @(negedge ref_clk);
      sda_low = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_low = 1'b1;
      half();
      scl = 1'b0;
   endtask

   task automatic stop_cond();
      @(negedge ref_clk);
      sda_low = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_low = 1'b0;
      half();
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_out(b[i], s);
      end
      bit_out(1'b1, s);
      ack = !s;
   endtask

   // Host acks every byte but the last, which gets a not-acknowledge
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_out(1'b1, s);
         b[i] = s;
      end
      bit_out(last, s);
   endtask

   // ----------------------------------------------------------------
   // Block transfers
   // ----------------------------------------------------------------
   task automatic block_write(input logic [6:0] addr, input logic [7:0] idx,
                              input logic [7:0] cnt, input logic [7:0] data [8],
                              input int n, output logic [7:0] acks);
      logic a;
      acks = 8'h00;
      start_cond();
      send_byte({addr, 1'b0}, a);
      acks = acks + {7'h00, a};
      send_byte(idx, a);
      acks = acks + {7'h00, a};
      send_byte(cnt, a);
      acks = acks + {7'h00, a};
      for (int i = 0; i < n; i++) begin
         send_byte(data[i], a);
         acks = acks + {7'h00, a};
      end
      stop_cond();
   endtask

   task automatic block_read(input logic [6:0] addr, input logic [7:0] idx, input int n,
                             output logic [7:0] cnt, output logic [7:0] data [8]);
      logic a;
      start_cond();
      send_byte({addr, 1'b0}, a);
      send_byte(idx, a);
      start_cond();
      send_byte({addr, 1'b1}, a);
      recv_byte(1'b0, cnt);
      for (int i = 0; i < n; i++) begin
         recv_byte(i == n - 1, data[i]);
      end
      stop_cond();
   endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the control register block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [6:0] ADDR = clkgen_regs_pkg::DEV_ADDR_DEFAULT;
   localparam logic [7:0] B5 = {clkgen_regs_pkg::REV_CODE, clkgen_regs_pkg::MAKER_CODE};
   localparam logic [7:0] B6 = {clkgen_regs_pkg::FAMILY_CODE, clkgen_regs_pkg::PART_CODE};

   logic       ref_clk, rstn, scl, host_low, sda_out, sda_oe, ref_run_in_pd, ref_out_en;
   logic [3:0] edge_rate_sel_out;
   logic [1:0] ref_edge_rate;
   logic [7:0] wr [8];
   logic [7:0] rd [8];
   logic [7:0] cnt, acks;
   int         miscompares, total_checks;
   // Pull-up: the line is high unless some party pulls it low
   wire        sda_line = !(host_low || (sda_oe && !sda_out));

   clock_gen_control_regs #(.DEV_ADDR(ADDR)) clock_gen_control_regs_inst (
      .ref_clk(ref_clk), .rstn(rstn), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .edge_rate_sel_out(edge_rate_sel_out),
      .ref_edge_rate(ref_edge_rate), .ref_run_in_pd(ref_run_in_pd), .ref_out_en(ref_out_en));

   smbus_host_model smbus_host_model_inst (
      .ref_clk(ref_clk), .sda(sda_line), .scl(scl), .sda_low(host_low));

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   function automatic logic [7:0] outs();
      return {ref_edge_rate, ref_run_in_pd, ref_out_en, edge_rate_sel_out};
   endfunction

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic reset_defaults();
      check(outs(), 8'h5F);
      smbus_host_model_inst.block_read(ADDR, 8'h02, 6, cnt, rd);
      check(cnt, 8'h08);
      check(rd[0], 8'h0F);
      check(rd[1], 8'h5F);
      check(rd[2], 8'hFF);
      check(rd[3], B5);
      check(rd[4], B6);
      check(rd[5], 8'h08);
   endtask

   // Reserved bits and read-only bytes are written too and must not stick
   task automatic write_all();
      wr = '{8'hF5, 8'hA0, 8'h00, 8'h00, 8'h00, 8'hF3, 8'h00, 8'h00};
      smbus_host_model_inst.block_write(ADDR, 8'h02, 8'h06, wr, 6, acks);
      check(acks, 8'h09);
      check(outs(), 8'hA5);
      smbus_host_model_inst.block_read(ADDR, 8'h02, 6, cnt, rd);
      check(cnt, 8'h13);
      check(rd[0], 8'h05);
      check(rd[1], 8'hAF);
      check(rd[2], 8'hFF);
      check(rd[3], B5);
      check(rd[4], B6);
      check(rd[5], 8'h13);
   endtask

   task automatic ref_codes();
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = i[1:0];
         wr[0] = {c, c[0], c[1], 4'h0};
         smbus_host_model_inst.block_write(ADDR, 8'h03, 8'h01, wr, 1, acks);
         check(acks, 8'h04);
         check(outs(), {c, c[0], c[1], 4'h5});
      end
   endtask

   // A byte beyond the count is acknowledged but must not reach index 3
   task automatic extra_dropped();
      wr[0] = 8'h00;
      wr[1] = 8'h00;
      smbus_host_model_inst.block_write(ADDR, 8'h02, 8'h01, wr, 2, acks);
      check(acks, 8'h05);
      check(outs(), 8'hF0);
   endtask

   task automatic wrong_addr();
      wr[0] = 8'hFF;
      smbus_host_model_inst.block_write(ADDR ^ 7'h01, 8'h02, 8'h01, wr, 1, acks);
      check(acks, 8'h00);
      check(outs(), 8'hF0);
   endtask

   // ----------------------------------------------------------------
   // Clock, reset, sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   initial begin
      miscompares = 0;
      total_checks = 0;
      rstn = 1'b0;
      repeat (3) @(negedge ref_clk);
      rstn = 1'b1;
      @(negedge ref_clk);
      reset_defaults();
      write_all();
      ref_codes();
      extra_dropped();
      wrong_addr();
      conclude();
   end

   initial begin
      for (int i = 0; i < 40000; i++) begin
         @(posedge ref_clk);
      end
      miscompares++;
      $display("watchdog expired at %0t", $time);
      conclude();
   end
endmodule
`default_nettype wire
